// file: rtl/phy_ctrl_energy_detect_regs.svh
// register offsets, field positions, reset values and timing for the control register pair
`ifndef PHY_CTRL_ENERGY_DETECT_REGS_SVH
`define PHY_CTRL_ENERGY_DETECT_REGS_SVH
`define ADDR_PHY_CONTROL_TWO     5'h1c
`define ADDR_ENERGY_DETECT_CTRL  5'h1d
`define BROADCAST_PHY_ADDR       5'h1f
`define PC2_SYNC_BIT             13
`define PC2_RXCLK_OUT_BIT        12
`define PC2_BCAST_BIT            11
`define PC2_COMPAT_BIT           10
`define PC2_SOFT_RESET_BIT       9
`define PC2_CLKOUT_DIS_BIT       1
`define PC2_RSVD0_BIT            0
`define ENERGY_DETECT_ENABLE_BIT                15
`define AUTO_POWER_UP_BIT           14
`define AUTO_POWER_DOWN_BIT         13
`define MANUAL_POWER_CHANGE_BIT               12
`define PULSE_BURST_DISABLE_BIT         11
`define ED_STATE_BIT             10
`define ED_ERR_MET_BIT           9
`define ED_DATA_MET_BIT          8
`define ED_ERR_CNT_HI            7
`define ED_ERR_CNT_LO            4
`define ED_DATA_CNT_HI           3
`define ED_DATA_CNT_LO           0
`define ED_THRESH_RESET          4'h1
`define ED_BURST_PULSES          3'h4
`define ED_SINGLE_PULSE          3'h1
`define ED_CTRL_RESET            16'h6011
`define ED_IDLE_TIMEOUT_MS       2000
`define CLK_RATE_HZ              20000000
`define SOFT_RESET_CYCLES        4'h8
`endif

// file: rtl/phy_ctrl_energy_detect_pkg.sv
// types shared by the control register pair
package phy_ctrl_energy_detect_pkg;
	typedef struct packed {
		logic       write;   // write strobe
		logic       read;    // read strobe
		logic [4:0] phy;     // addressed phy
		logic [4:0] reg_idx; // register index
		logic [15:0] data;   // write data
	} mgmt_req_s;
	typedef enum logic [1:0] {ED_OFF, ED_DOWN, ED_UP} ed_state_e;
	typedef enum logic [1:0] {MAC_MII, MAC_RMII_MASTER, MAC_RMII_SLAVE} mac_mode_e;
endpackage

// file: rtl/phy_ctrl_energy_detect_regs.sv
// control register 2 and energy detect control with their datapath effects
`timescale 1ns/1ps
`include "phy_ctrl_energy_detect_regs.svh"
module phy_ctrl_energy_detect_regs
	import phy_ctrl_energy_detect_pkg::*;
#(
	parameter int IDLE_CYCLES = `ED_IDLE_TIMEOUT_MS * (`CLK_RATE_HZ / 1000)
)(
	input  wire logic        i_clk,          // 20 MHz clock
	input  wire logic        i_rst_b,        // async reset, active low
	input  wire mgmt_req_s   i_req,          // management access
	input  wire logic [4:0]  i_phy_addr,     // local phy address
	input  wire logic        i_strap_clkout_dis, // strap, caught after reset
	input  wire logic        i_speed_100,    // link at 100 Mb/s
	input  wire mac_mode_e   i_mac_mode,     // mac interface mode
	input  wire logic        i_energy,       // energy present on line
	input  wire logic        i_data_event,   // energy detect data event pulse
	input  wire logic        i_err_event,    // energy detect error event pulse
	input  wire logic        i_cd_power_up,  // common driver power up pulse
	output logic [15:0]      o_rdata,        // read data
	output logic             o_tx_sync_rx,   // transmit on recovered clock
	output logic             o_clkout_rx,    // clock out carries recovered clock
	output logic             o_clkout_en,    // clock output pin enabled
	output logic             o_compat_pins,  // legacy pin arrangement
	output logic             o_soft_reset,   // core reset, registers kept
	output logic             o_ed_powered,   // energy detect powered up
	output logic             o_ed_pulse      // energy detect data pulse
);
	logic [15:0] pc2, next_pc2, edc, next_edc;
	logic [15:0] next_rdata;
	logic        strap_done, next_strap_done;
	ed_state_e   st, next_st;
	logic [3:0]  dcnt, next_dcnt, ecnt, next_ecnt;
	logic [31:0] idle, next_idle;
	logic [2:0]  burst, next_burst;
	logic [3:0]  srst, next_srst;
	logic        next_tx_sync, next_clkout_rx, next_clkout_en, next_compat, next_pulse;
	logic        wr_ok, wr_pc2, wr_edc, rd_edc, rd_own, manual;

	function automatic logic [3:0] sat_inc(input logic [3:0] v);
		sat_inc = (v == 4'hf) ? v : v + 4'h1;
	endfunction

	always_comb
	begin
		wr_ok = i_req.write && (i_req.phy == i_phy_addr ||
			(pc2[`PC2_BCAST_BIT] && i_req.phy == `BROADCAST_PHY_ADDR));
		rd_own = i_req.read && i_req.phy == i_phy_addr;
		wr_pc2 = wr_ok && i_req.reg_idx == `ADDR_PHY_CONTROL_TWO;
		wr_edc = wr_ok && i_req.reg_idx == `ADDR_ENERGY_DETECT_CTRL;
		rd_edc = rd_own && i_req.reg_idx == `ADDR_ENERGY_DETECT_CTRL;
		manual = wr_edc && i_req.data[`MANUAL_POWER_CHANGE_BIT];
		next_pc2 = pc2;
		next_strap_done = 1'b1;
		if (!strap_done)
			next_pc2[`PC2_CLKOUT_DIS_BIT] = i_strap_clkout_dis;
		if (wr_pc2)
		begin
			next_pc2 = 16'h0000;
			next_pc2[`PC2_SYNC_BIT] = i_req.data[`PC2_SYNC_BIT];
			next_pc2[`PC2_RXCLK_OUT_BIT] = i_req.data[`PC2_RXCLK_OUT_BIT];
			next_pc2[`PC2_BCAST_BIT] = i_req.data[`PC2_BCAST_BIT];
			next_pc2[`PC2_COMPAT_BIT] = i_req.data[`PC2_COMPAT_BIT];
			next_pc2[`PC2_CLKOUT_DIS_BIT] = i_req.data[`PC2_CLKOUT_DIS_BIT];
			next_pc2[`PC2_RSVD0_BIT] = i_req.data[`PC2_RSVD0_BIT];
		end
		// soft reset: hold core reset a few cycles, bit reads 1 until done
		next_srst = srst;
		if (wr_pc2 && i_req.data[`PC2_SOFT_RESET_BIT])
			next_srst = `SOFT_RESET_CYCLES;
		else if (srst != 4'h0)
			next_srst = srst - 4'h1;
		next_pc2[`PC2_SOFT_RESET_BIT] = (next_srst != 4'h0);
		next_tx_sync = pc2[`PC2_SYNC_BIT] && i_speed_100 &&
			(i_mac_mode == MAC_MII || i_mac_mode == MAC_RMII_MASTER);
		next_clkout_rx = pc2[`PC2_RXCLK_OUT_BIT] && i_speed_100;
		next_clkout_en = !pc2[`PC2_CLKOUT_DIS_BIT];
		next_compat = pc2[`PC2_COMPAT_BIT];
	end

	always_comb
	begin
		next_edc = edc;
		if (wr_edc)
		begin
			next_edc[`ENERGY_DETECT_ENABLE_BIT:`PULSE_BURST_DISABLE_BIT] = i_req.data[`ENERGY_DETECT_ENABLE_BIT:`PULSE_BURST_DISABLE_BIT];
			next_edc[`MANUAL_POWER_CHANGE_BIT] = 1'b0;
			next_edc[`ED_ERR_CNT_HI:`ED_DATA_CNT_LO] = i_req.data[`ED_ERR_CNT_HI:`ED_DATA_CNT_LO];
		end
		next_st = st;
		next_dcnt = dcnt;
		next_ecnt = ecnt;
		next_idle = idle;
		// new enable value used so a disabling write never leaves state reading powered
		if (!next_edc[`ENERGY_DETECT_ENABLE_BIT] || srst != 4'h0)
		begin
			next_st = ED_OFF;
			next_dcnt = 4'h0;
			next_ecnt = 4'h0;
			next_idle = 32'h0;
		end
		else
		begin
			if (i_data_event)
			begin
				next_dcnt = sat_inc(dcnt);
				next_idle = 32'h0;
			end
			else if (idle >= IDLE_CYCLES - 1)
			begin
				next_dcnt = 4'h0;
				next_ecnt = 4'h0;
				next_idle = 32'h0;
			end
			else
				next_idle = idle + 32'h1;
			if (i_err_event)
				next_ecnt = sat_inc(ecnt);
			if (st == ED_OFF)
				next_st = ED_UP;
			else if (manual)
			begin
				next_st = (st == ED_UP) ? ED_DOWN : ED_UP;
				next_dcnt = 4'h0;
			end
			else if (st == ED_DOWN && edc[`AUTO_POWER_UP_BIT] &&
				next_dcnt >= edc[`ED_DATA_CNT_HI:`ED_DATA_CNT_LO])
			begin
				next_st = ED_UP;
				next_dcnt = 4'h0;
			end
			else if (st == ED_UP && edc[`AUTO_POWER_DOWN_BIT] && !i_energy)
				next_st = ED_DOWN;
		end
		// met flags: event wins over clear on read
		if (rd_edc)
		begin
			next_edc[`ED_DATA_MET_BIT] = 1'b0;
			next_edc[`ED_ERR_MET_BIT] = 1'b0;
		end
		if (edc[`ENERGY_DETECT_ENABLE_BIT] && dcnt >= edc[`ED_DATA_CNT_HI:`ED_DATA_CNT_LO] && dcnt != 4'h0)
			next_edc[`ED_DATA_MET_BIT] = 1'b1;
		if (edc[`ENERGY_DETECT_ENABLE_BIT] && ecnt >= edc[`ED_ERR_CNT_HI:`ED_ERR_CNT_LO] && ecnt != 4'h0)
			next_edc[`ED_ERR_MET_BIT] = 1'b1;
		next_edc[`ED_STATE_BIT] = (next_st == ED_UP);
		next_burst = burst;
		next_pulse = 1'b0;
		if (srst != 4'h0)
			next_burst = 3'h0;
		else if (i_cd_power_up)
			next_burst = edc[`PULSE_BURST_DISABLE_BIT] ? `ED_SINGLE_PULSE : `ED_BURST_PULSES;
		else if (burst != 3'h0)
		begin
			next_pulse = ~o_ed_pulse;
			if (o_ed_pulse)
				next_burst = burst - 3'h1;
		end
		next_rdata = o_rdata;
		if (rd_own)
		begin
			if (i_req.reg_idx == `ADDR_PHY_CONTROL_TWO)
				next_rdata = pc2;
			else if (i_req.reg_idx == `ADDR_ENERGY_DETECT_CTRL)
				next_rdata = edc;
			else
				next_rdata = 16'h0000;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			pc2          <= 16'h0000;
			edc          <= `ED_CTRL_RESET;
			strap_done   <= 1'b0;
			st           <= ED_OFF;
			dcnt         <= 4'h0;
			ecnt         <= 4'h0;
			idle         <= 32'h0;
			burst        <= 3'h0;
			srst         <= 4'h0;
			o_rdata      <= 16'h0000;
			o_tx_sync_rx <= 1'b0;
			o_clkout_rx  <= 1'b0;
			o_clkout_en  <= 1'b0;
			o_compat_pins <= 1'b0;
			o_soft_reset <= 1'b0;
			o_ed_powered <= 1'b0;
			o_ed_pulse   <= 1'b0;
		end
		else
		begin
			pc2          <= next_pc2;
			edc          <= next_edc;
			strap_done   <= next_strap_done;
			st           <= next_st;
			dcnt         <= next_dcnt;
			ecnt         <= next_ecnt;
			idle         <= next_idle;
			burst        <= next_burst;
			srst         <= next_srst;
			o_rdata      <= next_rdata;
			o_tx_sync_rx <= next_tx_sync;
			o_clkout_rx  <= next_clkout_rx;
			o_clkout_en  <= next_clkout_en;
			o_compat_pins <= next_compat;
			o_soft_reset <= (next_srst != 4'h0);
			o_ed_powered <= (next_st == ED_UP);
			o_ed_pulse   <= next_pulse;
		end
	end
endmodule

// file: dv/phy_ctrl_regs_chk.sv
// assertion checker for the control register pair
`timescale 1ns/1ps
module phy_ctrl_regs_chk
	import phy_ctrl_energy_detect_pkg::*;
(
	input wire logic        i_clk,        // clk
	input wire logic        i_rst_b,      // rst
	input wire mgmt_req_s   i_req,        // access
	input wire logic [4:0]  i_phy_addr,   // own phy
	input wire logic        i_speed_100,  // speed
	input wire mac_mode_e   i_mac_mode,   // mode
	input wire logic [15:0] o_rdata,      // rdata
	input wire logic        o_tx_sync_rx, // tx sync
	input wire logic        o_clkout_rx,  // clk sel
	input wire logic        o_clkout_en,  // clk en
	input wire logic        o_compat_pins, // compat
	input wire logic        o_soft_reset  // soft rst
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);
	logic own;
	assign own = i_req.phy == i_phy_addr;
	sequence wr_pc2; i_req.write && own && i_req.reg_idx == 5'h1c; endsequence
	sequence rd_pc2; i_req.read && own && i_req.reg_idx == 5'h1c; endsequence
	sequence rd_edc; i_req.read && own && i_req.reg_idx == 5'h1d; endsequence
	sequence sr_run; o_soft_reset [*8] ##1 !o_soft_reset; endsequence
	tx_sync_a: assert property (o_tx_sync_rx |-> $past(i_speed_100) && $past(i_mac_mode) != MAC_RMII_SLAVE)
		else $error("tx sync without conditions");
	rx_clkout_a: assert property (o_clkout_rx |-> $past(i_speed_100))
		else $error("recovered clock out at 10M");
	soft_reset_len_a: assert property ($rose(o_soft_reset) |-> sr_run)
		else $error("soft reset length");
	clkout_en_a: assert property (wr_pc2 |-> ##2 o_clkout_en == !$past(i_req.data[1], 2))
		else $error("clock out enable");
	compat_pins_a: assert property (wr_pc2 |-> ##2 o_compat_pins == $past(i_req.data[10], 2))
		else $error("compat pins");
	reserved_zero_a: assert property (rd_pc2 |=> o_rdata[15:14] == 2'h0 && o_rdata[8:2] == 7'h0)
		else $error("reserved bits set");
	manual_clear_a: assert property (rd_edc |=> !o_rdata[12])
		else $error("manual bit reads one");
	ed_off_a: assert property (rd_edc |=> o_rdata[15] || !o_rdata[10])
		else $error("powered while disabled");
endmodule
bind phy_ctrl_energy_detect_regs phy_ctrl_regs_chk u_chk (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_req(i_req),
	.i_phy_addr(i_phy_addr), .i_speed_100(i_speed_100), .i_mac_mode(i_mac_mode), .o_rdata(o_rdata),
	.o_tx_sync_rx(o_tx_sync_rx), .o_clkout_rx(o_clkout_rx), .o_clkout_en(o_clkout_en),
	.o_compat_pins(o_compat_pins), .o_soft_reset(o_soft_reset));

// file: dv/mgmt_host.sv
// station management host issuing one access per call
`timescale 1ns/1ps
module mgmt_host
	import phy_ctrl_energy_detect_pkg::*;
(
	input  wire logic i_clk, // clk
	output mgmt_req_s o_req  // access
);
	initial o_req = '0;
	// idle fields inverted so stale data never looks valid
	task automatic acc(input logic w, input logic [4:0] p, input logic [4:0] r, input logic [15:0] d);
		@(posedge i_clk);
		o_req <= '{w, !w, p, r, d};
		@(posedge i_clk);
		o_req <= '{1'b0, 1'b0, ~p, ~r, ~d};
	endtask
endmodule

// file: dv/test_phy_ctrl_energy_detect_regs.sv
// self-checking bench for the control register pair
`timescale 1ns/1ps
module test_phy_ctrl_energy_detect_regs
	import phy_ctrl_energy_detect_pkg::*;
;
	typedef struct packed {logic [4:0] r; logic [15:0] d; logic [15:0] e; logic [3:0] o;} row_s;
	row_s rows [5] = '{'{5'h1c, 16'hfdfe, 16'h3c02, 4'hd}, '{5'h1d, 16'h6f11, 16'h6811, 4'hd},
		'{5'h1e, 16'hffff, 16'h0000, 4'hd}, '{5'h1c, 16'h0000, 16'h0000, 4'h2}, '{5'h1d, 16'h6011, 16'h6011, 4'h2}};
	logic clk = 0, rst_b = 0, spd = 1, nrg = 1, dev = 0, cdp = 0;
	mac_mode_e mode = MAC_MII;
	mgmt_req_s req;
	logic [15:0] rdata;
	logic tx, crx, cen, cmp, srst, pwr, pls;
	int err_total = 0, check_count = 0, cyc = 0, n, k;
	always #25 clk = ~clk;
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			err_total++;
			complete_run;
		end
	end
	mgmt_host u_host (.i_clk(clk), .o_req(req));
	phy_ctrl_energy_detect_regs #(.IDLE_CYCLES(50)) u_dut (.i_clk(clk), .i_rst_b(rst_b), .i_req(req),
		.i_phy_addr(5'h01), .i_strap_clkout_dis(1'b1), .i_speed_100(spd), .i_mac_mode(mode), .i_energy(nrg),
		.i_data_event(dev), .i_err_event(1'b0), .i_cd_power_up(cdp), .o_rdata(rdata), .o_tx_sync_rx(tx),
		.o_clkout_rx(crx), .o_clkout_en(cen), .o_compat_pins(cmp), .o_soft_reset(srst), .o_ed_powered(pwr),
		.o_ed_pulse(pls));
	task automatic cmp16(string nm, logic [15:0] e, logic [15:0] s);
		check_count++;
		if (s !== e)
		begin
			err_total++;
			$display("wrong value %s exp %h got %h", nm, e, s);
		end
	endtask
	task automatic rd(logic [4:0] r, logic [15:0] e);
		u_host.acc(1'b0, 5'h01, r, 16'h0);
		#1 cmp16("rdata", e, rdata);
	endtask
	task automatic wr(logic [4:0] p, logic [4:0] r, logic [15:0] d);
		u_host.acc(1'b1, p, r, d);
	endtask
	// counts high cycles of a flag over a window
	task automatic tally(ref logic s, input int len);
		k = 0;
		repeat (len)
		begin
			#1 k += int'(s);
			@(posedge clk);
		end
	endtask
	task automatic ev;
		@(posedge clk) dev <= 1'b1;
		@(posedge clk) dev <= 1'b0;
	endtask
	task automatic complete_run;
		$display("checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial
	begin
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		repeat (2) @(posedge clk);
		rd(5'h1c, 16'h0002);
		rd(5'h1d, 16'h6011);
		cmp16("cen", 16'h0, 16'(cen));
		foreach (rows[i])
		begin
			wr(5'h01, rows[i].r, rows[i].d);
			rd(rows[i].r, rows[i].e);
			cmp16("levels", 16'(rows[i].o), 16'({tx, crx, cen, cmp}));
		end
		wr(5'h01, 5'h1c, 16'h3000);
		for (n = 0; n < 6; n++)
		begin
			@(posedge clk);
			mode <= mac_mode_e'(n % 3);
			spd <= n < 3;
			@(posedge clk);
			#1 cmp16("tx", 16'(spd && mode != MAC_RMII_SLAVE), 16'(tx));
			cmp16("crx", 16'(spd), 16'(crx));
		end
		wr(5'h1f, 5'h1c, 16'h0400);
		wr(5'h03, 5'h1c, 16'h0400);
		rd(5'h1c, 16'h3000);
		wr(5'h01, 5'h1c, 16'h0800);
		wr(5'h1f, 5'h1c, 16'h0e00);
		tally(srst, 12);
		cmp16("srst", 16'h8, 16'(k));
		rd(5'h1c, 16'h0c00);
		wr(5'h01, 5'h1d, 16'he011);
		repeat (3) @(posedge clk);
		#1 cmp16("pwr", 16'h1, 16'(pwr));
		@(posedge clk) nrg <= 1'b0;
		repeat (4) @(posedge clk);
		#1 cmp16("pwr", 16'h0, 16'(pwr));
		@(posedge clk) nrg <= 1'b1;
		ev;
		repeat (3) @(posedge clk);
		#1 cmp16("pwr", 16'h1, 16'(pwr));
		wr(5'h01, 5'h1d, 16'hf011);
		repeat (3) @(posedge clk);
		#1 cmp16("pwr", 16'h0, 16'(pwr));
		wr(5'h01, 5'h1d, 16'he012);
		repeat (60) @(posedge clk);
		ev;
		repeat (60) @(posedge clk);
		ev;
		repeat (3) @(posedge clk);
		#1 cmp16("pwr", 16'h0, 16'(pwr));
		ev;
		repeat (3) @(posedge clk);
		#1 cmp16("pwr", 16'h1, 16'(pwr));
		for (n = 0; n < 2; n++)
		begin
			wr(5'h01, 5'h1d, n ? 16'he812 : 16'he012);
			@(posedge clk) cdp <= 1'b1;
			@(posedge clk) cdp <= 1'b0;
			tally(pls, 14);
			cmp16("pulses", n ? 16'h1 : 16'h4, 16'(k));
		end
		// reset in mid-run: registers back to reset values, strap reloaded
		@(posedge clk) rst_b <= 1'b0;
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		repeat (2) @(posedge clk);
		rd(5'h1c, 16'h0002);
		rd(5'h1d, 16'h6011);
		#1 cmp16("cen", 16'h0, 16'(cen));
		cmp16("pwr", 16'h0, 16'(pwr));
		complete_run;
	end
endmodule
